/* File: src/burst_port.sv */
/*
 * Bus bridge with a master sequencer and a target port.
 * The master side takes a request from an on-chip engine on clk_i and cuts
 * it into bursts on the link clock; the target side takes external writes
 * on the link clock and moves them through a two-entry buffer to memory.
 * Assumes the link clock is a free running bus clock from the other party.
 */
`timescale 1ns/1ps
module burst_port
(
    // System clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Link clock from the bus.
    input wire logic link_clk_i,
    // Master request from the on-chip engine.
    input wire logic mreq_valid_i,
    input wire logic [31:0] mreq_addr_i,
    input wire logic [15:0] mreq_words_i,
    output logic mreq_ready_o,
    output logic mreq_done_o,
    // Master side of the link.
    output logic lm_frame_o,
    output logic lm_addr_phase_o,
    output logic [31:0] lm_ad_o,
    input wire logic lm_ack_i,
    // Target side of the link.
    input wire logic lt_valid_i,
    input wire logic [31:0] lt_data_i,
    output logic lt_wait_o,
    output logic lt_retry_o,
    // Memory side of the target path.
    output logic mem_valid_o,
    output logic [31:0] mem_data_o,
    input wire logic mem_ready_i,
    input wire logic mem_stall_i
);
    import burst_port_pkg::*;

    // ************************************************************
    // Reset and request crossing
    // ************************************************************
    // Reset is brought into the link domain by two flip-flops.
    logic lrst_a_q, lrst_n_q;
    always_ff @(posedge link_clk_i) begin
        lrst_a_q <= reset_n_i;
        lrst_n_q <= lrst_a_q;
    end

    // Request words held stable on clk_i while the toggle crosses.
    logic [31:0] req_addr_q;
    logic [15:0] req_words_q;
    logic req_tgl_q, busy_q, done_q;
    logic dn_a_q, dn_b_q, dn_c_q;
    // Completion toggle, kept in the link domain; it flips once per finished request.
    logic dn_tgl_q;
    // Engine hands over one request at a time.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            req_addr_q <= ZERO_WORD;
            req_words_q <= 16'h0000;
            req_tgl_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (mreq_valid_i && !busy_q && mreq_words_i != 16'h0000) begin
            req_addr_q <= mreq_addr_i;
            req_words_q <= mreq_words_i;
            req_tgl_q <= ~req_tgl_q;
            busy_q <= 1'b1;
        end else if (dn_b_q != dn_c_q) begin
            busy_q <= 1'b0;
        end
    end
    // Completion toggle returns from the link domain.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            dn_a_q <= 1'b0;
            dn_b_q <= 1'b0;
            dn_c_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            dn_a_q <= dn_tgl_q;
            dn_b_q <= dn_a_q;
            dn_c_q <= dn_b_q;
            done_q <= dn_b_q != dn_c_q;
        end
    end
    // Ready is a flop, so it looks one edge ahead: it drops at the very edge
    // that takes a request and never shows high while a request is in flight.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mreq_ready_o <= 1'b0;
        end else begin
            mreq_ready_o <= !busy_q && !(mreq_valid_i && mreq_words_i != 16'h0000);
        end
    end
    assign mreq_done_o = done_q;

    // ************************************************************
    // Master burst sequencer (link domain)
    // ************************************************************
    logic rq_a_q, rq_b_q, rq_c_q; // Request toggle: two stages and an edge copy.
    mst_state_t mst_q;
    logic [31:0] addr_q; // Next byte address to move.
    logic [15:0] left_q; // Words still to move.
    logic [3:0] beat_q; // Words moved in this burst.
    // Sequencer owns the master side of the link.
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            rq_a_q <= 1'b0;
            rq_b_q <= 1'b0;
            rq_c_q <= 1'b0;
            dn_tgl_q <= 1'b0;
            mst_q <= M_IDLE;
            addr_q <= ZERO_WORD;
            left_q <= 16'h0000;
            beat_q <= 4'h0;
            lm_frame_o <= 1'b0;
            lm_addr_phase_o <= 1'b0;
            lm_ad_o <= ZERO_WORD;
        end else begin
            rq_a_q <= req_tgl_q;
            rq_b_q <= rq_a_q;
            rq_c_q <= rq_b_q;
            case (mst_q)
                M_IDLE: begin
                    // Request words were stable for two edges already.
                    if (rq_b_q != rq_c_q) begin
                        addr_q <= req_addr_q;
                        left_q <= req_words_q;
                        mst_q <= M_ADDR;
                    end
                end
                M_ADDR: begin
                    // Each burst opens with its start address.
                    lm_frame_o <= 1'b1;
                    lm_addr_phase_o <= 1'b1;
                    lm_ad_o <= addr_q;
                    beat_q <= 4'h0;
                    mst_q <= M_DATA;
                end
                M_DATA: begin
                    lm_addr_phase_o <= 1'b0;
                    if (lm_ack_i && !lm_addr_phase_o) begin
                        addr_q <= addr_q + WORD_BYTES;
                        // Bus address moves with each word, naming the word in flight.
                        lm_ad_o <= addr_q + WORD_BYTES;
                        left_q <= left_q - 16'h0001;
                        beat_q <= beat_q + 4'h1;
                        // Close at the word limit or the end of the request.
                        if (beat_q == BURST_WORDS - 4'h1 || left_q == 16'h0001) begin
                            lm_frame_o <= 1'b0;
                            mst_q <= M_TURN;
                        end
                    end
                end
                M_TURN: begin
                    // One idle cycle, then the next burst or completion.
                    if (left_q != 16'h0000) begin
                        mst_q <= M_ADDR;
                    end else begin
                        dn_tgl_q <= ~dn_tgl_q;
                        mst_q <= M_IDLE;
                    end
                end
                default: mst_q <= M_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Target path: buffer and retry
    // ************************************************************
    // Stall level crosses into the link domain by two flip-flops.
    logic st_a_q, st_b_q;
    // Two-entry buffer; the write side is in the link domain, so it is a
    // gray-pointer queue with the read side on clk_i.
    logic [31:0] buf_q [BUF_DEPTH];
    logic [1:0] wp_q, rp_q; // Gray pointers, one wrap bit.
    logic [1:0] rp_a_q, rp_b_q, wp_a_q, wp_b_q;
    logic full_w, take_w;
    // Full when the write pointer is two ahead: in a two-bit gray count both bits
    // then differ. The read pointer is a synchronised copy, so full is pessimistic
    // for two link edges; that costs a wait cycle but never a word.
    assign full_w = (wp_q == ~rp_b_q);
    assign take_w = lt_valid_i && !full_w && !st_b_q;
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            st_a_q <= 1'b1;
            st_b_q <= 1'b1;
            rp_a_q <= 2'b00;
            rp_b_q <= 2'b00;
            wp_q <= 2'b00;
            lt_wait_o <= 1'b0;
            lt_retry_o <= 1'b0;
        end else begin
            st_a_q <= mem_stall_i;
            st_b_q <= st_a_q;
            rp_a_q <= rp_q;
            rp_b_q <= rp_a_q;
            // No length count: bursts run as long as the master keeps going.
            if (take_w) begin
                wp_q <= {wp_q[0], ~wp_q[1]};
            end
            lt_retry_o <= lt_valid_i && st_b_q;
            lt_wait_o <= lt_valid_i && full_w && !st_b_q;
        end
    end
    // Storage has no reset; the pointers alone say which entries hold data.
    always_ff @(posedge link_clk_i) begin
        if (take_w) begin
            buf_q[wp_q[1] ^ wp_q[0]] <= lt_data_i;
        end
    end
    // Read side of the buffer drains into memory on clk_i.
    logic empty_w, pop_w;
    assign empty_w = (rp_q == wp_b_q);
    assign pop_w = !empty_w && (!mem_valid_o || mem_ready_i);
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wp_a_q <= 2'b00;
            wp_b_q <= 2'b00;
            rp_q <= 2'b00;
            mem_valid_o <= 1'b0;
            mem_data_o <= ZERO_WORD;
        end else begin
            wp_a_q <= wp_q;
            wp_b_q <= wp_a_q;
            if (pop_w) begin
                mem_data_o <= buf_q[rp_q[1] ^ rp_q[0]];
                mem_valid_o <= 1'b1;
                rp_q <= {rp_q[0], ~rp_q[1]};
            end else if (mem_ready_i) begin
                mem_valid_o <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_burst_limit;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (mst_q == M_DATA) |-> beat_q < BURST_WORDS;
    endproperty
    a_burst_limit: assert property (p_burst_limit) else $error("burst too long");
    property p_resume;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (mst_q == M_DATA && lm_ack_i && !lm_addr_phase_o) |=>
            addr_q == $past(addr_q) + WORD_BYTES && left_q == $past(left_q) - 16'h0001;
    endproperty
    a_resume: assert property (p_resume) else $error("address not advanced");
    property p_split;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (mst_q == M_TURN && left_q != 16'h0000) |=> mst_q == M_ADDR ##1 lm_frame_o;
    endproperty
    a_split: assert property (p_split) else $error("no next burst");
    property p_retry;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (lt_valid_i && st_b_q) |=> lt_retry_o && !lt_wait_o;
    endproperty
    a_retry: assert property (p_retry) else $error("no retry in stall");
    property p_wait;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (lt_valid_i && full_w && !st_b_q) |=> lt_wait_o;
    endproperty
    a_wait: assert property (p_wait) else $error("no wait when full");
    property p_accept;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (lt_valid_i && !full_w && !st_b_q) |=> wp_q != $past(wp_q);
    endproperty
    a_accept: assert property (p_accept) else $error("word refused");
    property p_start;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (mst_q == M_IDLE && rq_b_q != rq_c_q) |=> ##1 lm_frame_o && lm_addr_phase_o;
    endproperty
    a_start: assert property (p_start) else $error("master did not start");
    property p_take;
        @(posedge clk_i) disable iff (!reset_n_i)
        (mreq_valid_i && !busy_q && mreq_words_i != 16'h0000) |=> busy_q && req_words_q != 16'h0000;
    endproperty
    a_take: assert property (p_take) else $error("request not taken");
    c_split: cover property (@(posedge link_clk_i) mst_q == M_TURN && left_q != 16'h0000);
    c_retry: cover property (@(posedge link_clk_i) lt_retry_o);
    c_wait: cover property (@(posedge link_clk_i) lt_wait_o);
    c_done: cover property (@(posedge clk_i) done_q);
    // A dropped frame must stay low for the turn cycle before the next burst.
    property p_turn;
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        $fell(lm_frame_o) |=> !lm_frame_o;
    endproperty
    a_turn: assert property (p_turn) else $error("no idle cycle between bursts");
    // A word that memory has not taken must stand unchanged, or it would be lost.
    property p_mem_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        (mem_valid_o && !mem_ready_i) |=> mem_valid_o && $stable(mem_data_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory word dropped");
    // A full eight-word burst reaching its last word.
    c_full_burst: cover property (@(posedge link_clk_i)
        mst_q == M_DATA && beat_q == BURST_WORDS - 4'h1 && lm_ack_i);
endmodule

/* File: src/burst_port_pkg.sv */
/*
 * Shared constants and types for the bus burst bridge.
 * Assumes a 32-bit parallel bus with byte addresses and word transfers.
 */
package burst_port_pkg;
    // Longest master burst in bytes and in 32-bit words.
    localparam int unsigned BURST_BYTES = 32;
    localparam logic [3:0] BURST_WORDS = 4'h8;
    // Byte step between successive words of a burst.
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    // Reset value of address and data registers.
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // Depth of the data buffer on the target path.
    localparam int unsigned BUF_DEPTH = 2;
    // Master sequencer states, kept on the link clock.
    typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} mst_state_t;
endpackage

/* File: bench/link_partner.sv */
/* Far-side agent: a target that acknowledges the port's master bursts and
   a master that writes words into the port. Assumes a free running link
   clock and the reset of the system domain. */
`timescale 1ns/1ps
module link_partner (
    // Clock, reset and bench control.
    input wire logic link_clk_i,
    input wire logic reset_n_i,
    input wire logic slow_i,
    input wire logic [15:0] send_words_i,
    // Master path of the port.
    input wire logic lm_frame_i,
    input wire logic lm_addr_phase_i,
    output logic lm_ack_o,
    // Target path of the port.
    input wire logic lt_wait_i,
    input wire logic lt_retry_i,
    output logic lt_valid_o,
    output logic [31:0] lt_data_o
);
    logic go_q; // Ack gate; toggles when slow to stretch bursts.
    logic [1:0] ph_q; // Offer, release, then judge the answer.
    logic [15:0] n_q; // Words accepted so far.
    // Acknowledge data cycles only, never the address phase.
    assign lm_ack_o = lm_frame_i & ~lm_addr_phase_i & go_q;
    always @(posedge link_clk_i) begin
        go_q <= (!reset_n_i || !slow_i) ? 1'b1 : ~go_q;
    end
    // A refused word is offered again, so no word is ever skipped.
    always @(posedge link_clk_i) begin
        if (!reset_n_i) begin
            lt_valid_o <= 1'b0;
            lt_data_o <= 32'h0000_0000;
            ph_q <= 2'h0;
            n_q <= 16'h0000;
        end else if (ph_q == 2'h0) begin
            if (n_q < send_words_i) begin
                lt_valid_o <= 1'b1;
                lt_data_o <= 32'hA500_0000 + {16'h0000, n_q};
                ph_q <= 2'h1;
            end
        end else if (ph_q == 2'h1) begin
            // Released data must not keep its last value.
            lt_valid_o <= 1'b0;
            lt_data_o <= ~lt_data_o;
            ph_q <= 2'h2;
        end else begin
            if (!lt_wait_i && !lt_retry_i) begin
                n_q <= n_q + 16'h0001;
            end
            ph_q <= 2'h0;
        end
    end
endmodule

/* File: bench/tb.sv */
/* Testbench for the burst port: master requests from a table, then target
   writes under buffer stall and memory stall. Assumes link_partner. */
`timescale 1ns/1ps
module tb;
    import burst_port_pkg::*;
    typedef struct packed {logic [31:0] addr; logic [15:0] words; logic slow;} row_t;
    // Base address, word count, slow acknowledge.
    localparam row_t ROWS [5] = '{'{32'h0000_1000, 16'h0001, 1'b0},
        '{32'h0000_2000, 16'h0008, 1'b0}, '{32'h0000_3000, 16'h0009, 1'b1},
        '{32'h0000_4000, 16'h0014, 1'b0}, '{32'h0000_5FF0, 16'h0010, 1'b1}};
    logic clk_i, link_clk_i, reset_n_i, mreq_valid_i, lm_ack_i, lt_valid_i, slow;
    logic mreq_ready_o, mreq_done_o, lm_frame_o, lm_addr_phase_o, lt_wait_o, lt_retry_o;
    logic mem_valid_o, mem_ready_i, mem_stall_i, saw_wait, saw_retry;
    logic [31:0] mreq_addr_i, lm_ad_o, lt_data_i, mem_data_o, exp_addr;
    logic [15:0] mreq_words_i, send_words;
    int n_mismatch, samples_checked, bursts, blen, moved, rcv, k;
    initial begin clk_i = 1'b0; forever #2.5 clk_i = ~clk_i; end
    initial begin link_clk_i = 1'b0; #1.3; forever #3 link_clk_i = ~link_clk_i; end
    burst_port dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
        .mreq_valid_i(mreq_valid_i), .mreq_addr_i(mreq_addr_i), .mreq_words_i(mreq_words_i),
        .mreq_ready_o(mreq_ready_o), .mreq_done_o(mreq_done_o), .lm_frame_o(lm_frame_o),
        .lm_addr_phase_o(lm_addr_phase_o), .lm_ad_o(lm_ad_o), .lm_ack_i(lm_ack_i),
        .lt_valid_i(lt_valid_i), .lt_data_i(lt_data_i), .lt_wait_o(lt_wait_o),
        .lt_retry_o(lt_retry_o), .mem_valid_o(mem_valid_o), .mem_data_o(mem_data_o),
        .mem_ready_i(mem_ready_i), .mem_stall_i(mem_stall_i));
    link_partner far_end (.link_clk_i(link_clk_i), .reset_n_i(reset_n_i), .slow_i(slow),
        .send_words_i(send_words), .lm_frame_i(lm_frame_o), .lm_addr_phase_i(lm_addr_phase_o),
        .lm_ack_o(lm_ack_i), .lt_wait_i(lt_wait_o), .lt_retry_i(lt_retry_o),
        .lt_valid_o(lt_valid_i), .lt_data_o(lt_data_i));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Link outputs are settled at the falling edge; follow bursts there.
    always @(negedge link_clk_i) begin
        if (lt_wait_o === 1'b1) saw_wait = 1'b1;
        if (lt_retry_o === 1'b1) saw_retry = 1'b1;
        if (lm_frame_o === 1'b1 && lm_addr_phase_o === 1'b1) begin
            check("burst_addr", lm_ad_o, exp_addr);
            bursts++;
            blen = 0;
        end else if (lm_frame_o === 1'b1 && lm_ack_i === 1'b1) begin
            check("word_addr", lm_ad_o, exp_addr);
            exp_addr = exp_addr + WORD_BYTES;
            blen++;
            moved++;
            check("burst_len_ok", 32'(blen <= int'(BURST_WORDS)), 32'h1);
        end
    end
    // Memory must see every target word once and in order.
    always @(posedge clk_i) begin
        if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1) begin
            check("mem_word", mem_data_o, 32'hA500_0000 + 32'(rcv));
            rcv++;
        end
    end
    initial begin #300000; n_mismatch++; final_report(); end
    initial begin
        reset_n_i = 1'b0; mreq_valid_i = 1'b0; mreq_addr_i = ZERO_WORD;
        mreq_words_i = 16'h0000; mem_ready_i = 1'b1; mem_stall_i = 1'b0; slow = 1'b0;
        send_words = 16'h0000; exp_addr = ZERO_WORD; saw_wait = 1'b0; saw_retry = 1'b0;
        n_mismatch = 0; samples_checked = 0; bursts = 0; moved = 0; rcv = 0;
        repeat (16) @(negedge clk_i);
        check("reset_outs", 32'({mreq_done_o, lm_frame_o, lt_wait_o, lt_retry_o,
            mem_valid_o}), 32'h0);
        reset_n_i = 1'b1;
        @(negedge clk_i);
        foreach (ROWS[i]) begin
            exp_addr = ROWS[i].addr; slow = ROWS[i].slow; bursts = 0; moved = 0;
            for (k = 0; k < 200 && mreq_ready_o !== 1'b1; k++) @(negedge clk_i);
            mreq_valid_i = 1'b1;
            mreq_addr_i = ROWS[i].addr;
            mreq_words_i = ROWS[i].words;
            @(negedge clk_i);
            mreq_valid_i = 1'b0;
            check("ready_busy", 32'(mreq_ready_o), 32'h0);
            for (k = 0; k < 4000 && mreq_done_o !== 1'b1; k++) @(negedge clk_i);
            check("done", 32'(mreq_done_o), 32'h1);
            check("moved", 32'(moved), 32'(ROWS[i].words));
            check("bursts", 32'(bursts), 32'((ROWS[i].words + 16'h7) / 16'h8));
        end
        // Memory holds off: buffer fills and the port must wait.
        mem_ready_i = 1'b0;
        send_words = 16'h0006;
        repeat (80) @(negedge clk_i);
        check("saw_wait", 32'(saw_wait), 32'h1);
        // Memory controller stalled: the port must answer with retries.
        mem_stall_i = 1'b1;
        mem_ready_i = 1'b1;
        send_words = 16'h001A;
        repeat (80) @(negedge clk_i);
        check("saw_retry", 32'(saw_retry), 32'h1);
        mem_stall_i = 1'b0;
        for (k = 0; k < 4000 && rcv < 26; k++) @(negedge clk_i);
        check("rcv_total", 32'(rcv), 32'h1A);
        final_report();
    end
endmodule
